// File: design/gtf_fsr_bank.sv
// One security copy of the global fault status and fault address.
// Assumes fault events and register writes come from the same clock.
module gtf_fsr_bank
   import gtf_pkg::*;
#(
   parameter logic [31:0] FSR_MASK = FSR_NS_MASK
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [31:0] impl_mask_i,
   input wire logic [63:0] far_mask_i,
   input wire logic fault_i,
   input wire logic [8:0] fault_flags_i,
   input wire logic [63:0] fault_addr_i,
   input wire logic w1c_i,
   input wire logic restore_i,
   input wire logic far_lo_we_i,
   input wire logic far_hi_we_i,
   input wire logic [31:0] wdata_i,
   output logic [31:0] fsr_o,
   output logic [63:0] far_o
);
   logic [31:0] fsr_r;
   logic [31:0] fsr_nxt;
   logic [31:0] set_bits;
   logic [31:0] mask;

   assign mask = FSR_MASK & impl_mask_i;
   assign fsr_o = fsr_r;

   always_comb
   begin
      set_bits = {23'h000000, fault_flags_i} & mask;
      if (fault_i && (fsr_r != 32'h00000000))
      begin
         set_bits[FSR_MULTI_BIT] = 1'b1;
      end
      fsr_nxt = fsr_r;
      if (restore_i)
      begin
         fsr_nxt = wdata_i & mask;
      end
      else if (w1c_i)
      begin
         fsr_nxt = fsr_r & ~(wdata_i & mask);
      end
      // A fault in the same cycle as a clear must not be lost.
      if (fault_i)
      begin
         fsr_nxt = fsr_nxt | set_bits;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         fsr_r <= FSR_RESET;
      end
      else
      begin
         fsr_r <= fsr_nxt;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         far_o <= FAR_RESET;
      end
      else if (fault_i)
      begin
         far_o <= fault_addr_i & far_mask_i;
      end
      else if (far_lo_we_i)
      begin
         far_o[31:0] <= wdata_i & far_mask_i[31:0];
      end
      else if (far_hi_we_i)
      begin
         far_o[63:32] <= wdata_i & far_mask_i[63:32];
      end
   end
endmodule

// File: design/gtf_pkg.sv
// Package for the global translation and fault register bank.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package gtf_pkg;
   localparam logic [7:0] OFF_REQ_LO = 8'h00;
   localparam logic [7:0] OFF_REQ_HI = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_FAR_LO = 8'h0C;
   localparam logic [7:0] OFF_FAR_HI = 8'h10;
   localparam logic [7:0] OFF_FSR = 8'h14;
   localparam logic [7:0] OFF_RESTORE = 8'h18;
   localparam logic [7:0] OFF_CFG = 8'h1C;
   localparam logic [7:0] OFF_ALIAS = 8'h40;
   localparam int REQ_ADDR_LSB = 12;
   localparam int REQ_NDX_MSB = 7;
   localparam int V1_ADDR_MSB = 31;
   localparam int STAT_ACTIVE_BIT = 0;
   localparam int FSR_MULTI_BIT = 31;
   localparam int FSR_UUT_BIT = 8;
   localparam int FSR_CAF_BIT = 7;
   localparam int FSR_EF_BIT = 6;
   localparam int FSR_PF_BIT = 5;
   localparam int FSR_UNIMPL_CONTEXT_IRQ_FLAG_BIT = 4;
   localparam int FSR_UNIMPL_CONTEXT_BANK_FLAG_BIT = 3;
   localparam int FSR_STREAM_MATCH_CONFLICT_FLAG_BIT = 2;
   localparam int FSR_USF_BIT = 1;
   localparam int FSR_ICF_BIT = 0;
   localparam logic [31:0] FSR_SEC_MASK = 32'h800001FF;
   localparam logic [31:0] FSR_NS_MASK = 32'h800000FF;
   localparam logic [31:0] FSR_RESET = 32'h00000000;
   localparam logic [63:0] FAR_RESET = 64'h0000000000000000;
   localparam logic [5:0] IAS_32 = 6'h20;
   localparam logic [5:0] IAS_36 = 6'h24;
   localparam logic [5:0] IAS_40 = 6'h28;
   localparam logic [5:0] NBITS_MAX = 6'h3F;

   typedef struct packed {
      logic valid;
      logic secure;
      logic [63:0] addr;
      logic [7:0] context_bank_index;
   } gtf_req_type;

   typedef struct packed {
      logic valid;
      logic secure;
      logic in_context_bank;
      logic [8:0] flags;
      logic [63:0] addr;
   } gtf_fault_type;
endpackage

// File: design/gtf_regs.sv
// Global translation request, translation status and global fault registers.
// Assumes a classic Wishbone master and an external translation engine and
// fault detector on the same clock.
//
// Overview of operation
// - Low-word write zero-extends; high-word write discarded.
// - Request: address 63:12, bank index 7:0.
// - Request write starts unprivileged-write translation.
// - Translation outcome goes to result register.
// - Access security selects request register copy.
// - Earlier version: 32-bit request, address 31:12.
// - Status bit 0 shows translation active.
// - Fault address captures input address, low N.
// - Later version: N from upstream bus size.
// - Earlier version: N is 32, 36, 40.
// - Write one clears fault status bit.
// - Further error while nonzero sets multi flag.
// - Bit 8 secure-only unsupported upstream flag.
// - Bits 4, 3 unimplemented context flags.
// - Bits 2, 1, 0 stream and context flags.
// - Permission and external flags; permission may be zero.
// - No configuration faults: flag reads zero.
// - Context bank faults skip global status.
// - Restore write overwrites whole fault status.
// - Each restore copy restores its own status.
// - Banked copies; secure alias reaches non-secure copy.
// - Other request variants share layout and result.
//
// Implementation choices: the address map and the Wishbone register port.
module gtf_regs
   import gtf_pkg::*;
#(
   parameter bit LEGACY_V1 = 1'b0,
   parameter logic [5:0] IAS_BITS = IAS_40,
   parameter logic [5:0] UBS_BITS = 6'h30,
   parameter bit CFG_FAULT_SUPPORTED = 1'b1,
   parameter bit PERM_FAULT_SUPPORTED = 1'b1
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic secure_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic err_o,
   output gtf_req_type xlate_req_o,
   input wire logic result_written_i,
   input wire logic result_secure_i,
   input wire gtf_fault_type fault_i,
   output logic [63:0] result_o,
   output logic result_valid_o,
   input wire logic [63:0] result_i,
   output logic ns_active_o,
   output logic s_active_o
);
   logic req_access;
   logic [7:0] reg_off;
   logic to_ns;
   logic known;
   logic wr;
   logic full_word;
   logic [31:0] impl_mask;
   logic [63:0] far_mask;
   logic [5:0] n_bits;
   logic [1:0] active_r;
   logic [31:0] fsr_s;
   logic [31:0] fsr_ns;
   logic [63:0] far_s;
   logic [63:0] far_ns;
   logic fault_s;
   logic fault_ns;
   logic [31:0] rdata;
   logic [7:0] cfg_r;
   logic req_wr;
   logic wr_s;
   logic wr_ns;
   logic w1c_s;
   logic w1c_ns;
   logic restore_s;
   logic restore_ns;
   logic far_lo_s;
   logic far_lo_ns;
   logic far_hi_s;
   logic far_hi_ns;

   function automatic logic [63:0] low_ones(input logic [5:0] n);
      logic [63:0] m;
      m = 64'h0000000000000000;
      for (int i = 0; i < 64; i++)
      begin
         m[i] = (i < int'(n));
      end
      return m;
   endfunction

   // Strobe for one register offset, shared by the write decodes in the strobe block below.
   function automatic logic hit(input logic en, input logic [7:0] off, input logic [7:0] tgt);
      return en && (off == tgt);
   endfunction

   // Only aligned offsets inside the bank are answered; the rest get an error.
   function automatic logic mapped(input logic [7:0] off);
      return (off <= OFF_CFG) && (off[1:0] == 2'b00);
   endfunction

   assign req_access = cyc_i && stb_i && !ack_o && !err_o;
   // Secure software reaching the alias window targets the non-secure copy.
   assign to_ns = !secure_i || (adr_i >= OFF_ALIAS);
   assign reg_off = (secure_i && adr_i >= OFF_ALIAS) ? adr_i - OFF_ALIAS : adr_i;
   assign known = mapped(reg_off);
   assign wr = req_access && we_i && known;
   assign full_word = (sel_i == 4'hF);

   // Register write strobes other than the configuration write are decoded here, one per security copy except the request strobe.
   always_comb
   begin
      wr_s = wr && full_word && !to_ns;
      wr_ns = wr && full_word && to_ns;
      req_wr = hit(wr && full_word, reg_off, OFF_REQ_LO);
      w1c_s = hit(wr_s, reg_off, OFF_FSR);
      w1c_ns = hit(wr_ns, reg_off, OFF_FSR);
      restore_s = hit(wr_s, reg_off, OFF_RESTORE);
      restore_ns = hit(wr_ns, reg_off, OFF_RESTORE);
      far_lo_s = hit(wr_s, reg_off, OFF_FAR_LO);
      far_lo_ns = hit(wr_ns, reg_off, OFF_FAR_LO);
      far_hi_s = hit(wr_s, reg_off, OFF_FAR_HI);
      far_hi_ns = hit(wr_ns, reg_off, OFF_FAR_HI);
   end

   assign n_bits = LEGACY_V1 ? IAS_BITS : UBS_BITS;
   assign far_mask = low_ones(n_bits);

   always_comb
   begin
      impl_mask = 32'hFFFFFFFF;
      impl_mask[FSR_CAF_BIT] = CFG_FAULT_SUPPORTED;
      impl_mask[FSR_PF_BIT] = PERM_FAULT_SUPPORTED;
   end

   // Accept a request only for a full 32-bit write; partial lanes are dropped.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         xlate_req_o <= '0;
      end
      else
      begin
         xlate_req_o.valid <= 1'b0;
         if (req_wr)
         begin
            xlate_req_o.valid <= 1'b1;
            xlate_req_o.secure <= !to_ns;
            xlate_req_o.addr <= {32'h00000000, dat_i[31:REQ_ADDR_LSB], 12'h000};
            xlate_req_o.context_bank_index <= dat_i[REQ_NDX_MSB:0];
            if (LEGACY_V1)
            begin
               xlate_req_o.addr[63:V1_ADDR_MSB + 1] <= 32'h00000000;
            end
         end
      end
   end

   // A request overlapping an active one is undefined; software waits first.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         active_r <= 2'b00;
      end
      else
      begin
         for (int b = 0; b < 2; b++)
         begin
            if (result_written_i && (result_secure_i == (b == 1)))
            begin
               active_r[b] <= 1'b0;
            end
            if (req_wr && ((!to_ns) == (b == 1)))
            begin
               active_r[b] <= 1'b1;
            end
         end
      end
   end
   assign ns_active_o = active_r[0];
   assign s_active_o = active_r[1];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         result_o <= 64'h0000000000000000;
      end
      else if (result_written_i)
      begin
         result_o <= result_i;
      end
   end

   // Sticky, so software can tell a real result from the reset value.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         result_valid_o <= 1'b0;
      end
      else if (result_written_i)
      begin
         result_valid_o <= 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cfg_r <= 8'h00;
      end
      else if (wr && reg_off == OFF_CFG && sel_i[0])
      begin
         cfg_r <= dat_i[7:0];
      end
   end

   // Faults tied to a context bank are recorded there, never here.
   assign fault_s = fault_i.valid && fault_i.secure && !fault_i.in_context_bank;
   assign fault_ns = fault_i.valid && !fault_i.secure && !fault_i.in_context_bank;

   gtf_fsr_bank #(
      .FSR_MASK(FSR_SEC_MASK)
   ) u_bank_s (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .impl_mask_i(impl_mask),
      .far_mask_i(far_mask),
      .fault_i(fault_s),
      .fault_flags_i(fault_i.flags),
      .fault_addr_i(fault_i.addr),
      .w1c_i(w1c_s),
      .restore_i(restore_s),
      .far_lo_we_i(far_lo_s),
      .far_hi_we_i(far_hi_s),
      .wdata_i(dat_i),
      .fsr_o(fsr_s),
      .far_o(far_s)
   );

   gtf_fsr_bank #(
      .FSR_MASK(FSR_NS_MASK)
   ) u_bank_ns (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .impl_mask_i(impl_mask),
      .far_mask_i(far_mask),
      .fault_i(fault_ns),
      .fault_flags_i(fault_i.flags),
      .fault_addr_i(fault_i.addr),
      .w1c_i(w1c_ns),
      .restore_i(restore_ns),
      .far_lo_we_i(far_lo_ns),
      .far_hi_we_i(far_hi_ns),
      .wdata_i(dat_i),
      .fsr_o(fsr_ns),
      .far_o(far_ns)
   );

   // Write-only registers read as zero, as do reserved bits.
   always_comb
   begin
      rdata = 32'h00000000;
      unique case (reg_off)
         OFF_STATUS:
         begin
            rdata[STAT_ACTIVE_BIT] = to_ns ? active_r[0] : active_r[1];
         end
         OFF_FAR_LO:
         begin
            rdata = to_ns ? far_ns[31:0] : far_s[31:0];
         end
         OFF_FAR_HI:
         begin
            rdata = to_ns ? far_ns[63:32] : far_s[63:32];
         end
         OFF_FSR:
         begin
            rdata = to_ns ? fsr_ns : fsr_s;
         end
         OFF_CFG:
         begin
            rdata = {18'h00000, n_bits, cfg_r};
         end
         default:
         begin
            rdata = 32'h00000000;
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
      end
      else
      begin
         ack_o <= req_access && known;
      end
   end

   // Unmapped or misaligned offsets answer with an error instead of an ack.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         err_o <= 1'b0;
      end
      else
      begin
         err_o <= req_access && !known;
      end
   end

   // Read data is zero whenever no read is answered, so stale values never leak.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dat_o <= 32'h00000000;
      end
      else
      begin
         dat_o <= (req_access && known && !we_i) ? rdata : 32'h00000000;
      end
   end
endmodule

// File: sim/gtf_regs_checker.sv
// Assertions for the global translation and fault register bank.
// Assumes a bind onto gtf_regs; sees only its ports, one clock.
module gtf_regs_checker
   import gtf_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic secure_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic err_o,
   input wire gtf_req_type xlate_req_o,
   input wire logic result_written_i,
   input wire logic result_secure_i,
   input wire logic ns_active_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic take;
   logic wreq;
   assign take = cyc_i && stb_i && !ack_o && !err_o;
   assign wreq = take && we_i && adr_i == OFF_REQ_LO && sel_i == 4'hF;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_req_starts: assert property (wreq |=> xlate_req_o.valid)
      else $error("request write gave no translation");
   a_req_fields: assert property (wreq |=> xlate_req_o.addr[63:32] == 32'h0
      && xlate_req_o.addr[31:12] == $past(dat_i[31:12])
      && xlate_req_o.context_bank_index == $past(dat_i[7:0]))
      else $error("request fields wrong");
   a_req_copy: assert property (wreq |=> xlate_req_o.secure == $past(secure_i))
      else $error("request copy wrong");
   a_hi_ignored: assert property (take && we_i && adr_i == OFF_REQ_HI |=> !xlate_req_o.valid)
      else $error("high word write started translation");
   a_req_single: assert property (xlate_req_o.valid |=> !xlate_req_o.valid)
      else $error("translation request repeated");
   a_active_set: assert property (xlate_req_o.valid && !xlate_req_o.secure |-> ns_active_o)
      else $error("active not raised");
   a_active_clear: assert property (result_written_i && !result_secure_i && !wreq
      |=> !ns_active_o)
      else $error("active not cleared");
   a_status_read: assert property (take && !we_i && adr_i == OFF_STATUS && !secure_i
      |=> dat_o == {31'h0, $past(ns_active_o)})
      else $error("status read wrong");
   a_alias_refused: assert property (take && !secure_i && adr_i[6] |=> err_o && !ack_o)
      else $error("non-secure alias access not refused");
   cover property (wreq ##1 xlate_req_o.valid);
   cover property (result_written_i ##1 !ns_active_o);
   cover property (err_o);
endmodule
bind gtf_regs gtf_regs_checker u_chk (.*);

// File: sim/gtf_regs_tb.sv
// Self-checking bench for the global translation and fault register bank.
// Assumes default parameters: later version, 48-bit fault address.
module gtf_regs_tb
   import gtf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic w; logic s; logic [7:0] a; logic [31:0] d; logic [31:0] e;} gtf_row_type;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, secure_i = 0;
   logic result_written_i = 0, result_secure_i = 0, result_valid_o, ack_o, err_o;
   logic ns_active_o, s_active_o, qe;
   logic [7:0] adr_i = 0;
   logic [3:0] sel_i = 0;
   logic [31:0] dat_i = 0, dat_o, q;
   logic [63:0] result_i = 0, result_o;
   gtf_req_type xlate_req_o, lreq;
   gtf_fault_type fault_i = '0;
   int num_errors = 0, num_checks = 0, nreq = 0, cyc_cnt = 0;
   gtf_row_type rows[13] = '{
      '{1'h0, 1'h0, 8'h08, 32'h0, 32'h0}, '{1'h0, 1'h0, 8'h14, 32'h0, 32'h0},
      '{1'h1, 1'h0, 8'h18, 32'hFFFFFFFF, 32'h0}, '{1'h1, 1'h1, 8'h18, 32'hFFFFFFFF, 32'h0},
      '{1'h0, 1'h0, 8'h14, 32'h0, 32'h800000FF}, '{1'h0, 1'h1, 8'h14, 32'h0, 32'h800001FF},
      '{1'h1, 1'h1, 8'h14, 32'h80000100, 32'h0}, '{1'h0, 1'h1, 8'h14, 32'h0, 32'h000000FF},
      '{1'h1, 1'h1, 8'h54, 32'h00000001, 32'h0}, '{1'h0, 1'h1, 8'h54, 32'h0, 32'h800000FE},
      '{1'h0, 1'h0, 8'h00, 32'h0, 32'h0}, '{1'h1, 1'h0, 8'h1C, 32'h000000A5, 32'h0},
      '{1'h0, 1'h0, 8'h1C, 32'h0, 32'h000030A5}};
   gtf_regs u_dut (.*);
   always #20 clk_i = ~clk_i;
   always @(posedge clk_i)
   begin
      if (xlate_req_o.valid === 1'b1)
      begin
         nreq++;
         lreq = xlate_req_o;
      end
      if (++cyc_cnt == 3000)
      begin
         num_errors++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      num_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Waits for ack or err with no assumed latency; releases for one cycle after.
   task automatic wb(input logic w, input logic s, input logic [7:0] a, input logic [31:0] d);
      cyc_i <= 1;
      stb_i <= 1;
      we_i <= w;
      secure_i <= s;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hF;
      do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
      q = dat_o;
      qe = err_o;
      cyc_i <= 0;
      stb_i <= 0;
      @(posedge clk_i);
   endtask
   task automatic fp(input logic s, input logic cb, input logic [8:0] f, input logic [63:0] a);
      fault_i <= '{1'b1, s, cb, f, a};
      @(posedge clk_i);
      fault_i.valid <= 0;
      @(posedge clk_i);
   endtask
   task automatic done_ok(input logic s);
      result_secure_i <= s;
      result_written_i <= 1;
      @(posedge clk_i);
      result_written_i <= 0;
      @(posedge clk_i);
   endtask
   task automatic tally_and_finish();
      if (num_errors == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      foreach (rows[i])
      begin
         wb(rows[i].w, rows[i].s, rows[i].a, rows[i].d);
         if (!rows[i].w)
            chk(q, rows[i].e);
      end
      wb(1, 0, 8'h18, 0);
      wb(1, 1, 8'h18, 0);
      fp(0, 0, 9'h104, 64'hFEDCBA9876543210);
      wb(0, 0, 8'h14, 0);
      chk(q, 32'h4);
      wb(0, 0, 8'h0C, 0);
      chk(q, 32'h76543210);
      wb(0, 0, 8'h10, 0);
      chk(q, 32'h0000BA98);
      fp(0, 1, 9'h2, 0);
      wb(0, 0, 8'h14, 0);
      chk(q, 32'h4);
      fp(0, 0, 9'h1, 0);
      wb(0, 0, 8'h14, 0);
      chk(q, 32'h80000005);
      fp(1, 0, 9'h118, 0);
      wb(0, 1, 8'h14, 0);
      chk(q, 32'h00000118);
      wb(1, 0, 8'h00, 32'hABCDE35A);
      chk(lreq.addr[63:12], 52'h00000000ABCDE);
      chk(lreq.context_bank_index, 8'h5A);
      wb(1, 0, 8'h04, 32'hFFFFFFFF);
      chk(64'(nreq), 64'h1);
      wb(0, 0, 8'h08, 0);
      chk(q, 32'h1);
      result_i <= 64'h123456789ABCDEF0;
      done_ok(0);
      chk(result_o, 64'h123456789ABCDEF0);
      chk(result_valid_o, 1'b1);
      chk({ns_active_o, s_active_o}, 2'h0);
      wb(1, 1, 8'h00, 32'h00001001);
      chk({lreq.secure, s_active_o, ns_active_o}, 3'h6);
      done_ok(1);
      wb(1, 1, 8'h40, 32'h00002000);
      chk({lreq.secure, ns_active_o}, 2'h1);
      done_ok(0);
      wb(0, 0, 8'h40, 0);
      chk(qe, 1'b1);
      wb(1, 0, 8'h00, 32'h00003000);
      rst_i <= 1;
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      chk({ns_active_o, result_valid_o}, 2'h0);
      wb(0, 1, 8'h14, 0);
      chk(q, 32'h0);
      tally_and_finish();
   end
endmodule
